// ### logic/timer_channel_control_mode.sv
// One 16-bit timer channel: command, mode, count and compare registers behind an AHB-Lite slave
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/10ps
module timer_channel_control_mode (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// External clock inputs
	input  wire logic        extClockIn0,
	input  wire logic        extClockIn1,
	input  wire logic        extClockIn2,
	// Line A
	input  wire logic        ioLineAIn,
	output logic             ioLineAOut,
	output logic             ioLineAOe,
	// Line B
	input  wire logic        ioLineBIn,
	output logic             ioLineBOut,
	output logic             ioLineBOe
);
	logic [31:0] modeReg;        // Mode register
	logic [15:0] liveCount;      // Counter value
	logic [15:0] regA;           // Compare/capture A
	logic [15:0] regB;           // Compare/capture B
	logic [15:0] regC;           // Compare C
	logic        countDown;      // Direction in up/down patterns
	logic        clkEnabled;     // Counter clock enabled
	logic        clkStopped;     // Counter clock stopped until trigger
	logic [15:0] prescale;       // Free-running internal clock divider
	logic        prevClkLevel;   // Previous gated clock level
	logic        prevLineA;      // Previous line A level
	logic        prevLineB;      // Previous line B level
	logic [2:0]  prevExt;        // Previous external clock levels
	logic        wrPending;      // Write data phase in progress
	logic [5:0]  wrOffset;       // Offset latched in address phase
	logic        next_lineA;     // Next line A output level
	logic        next_lineB;     // Next line B output level

	// Edge match against a two-bit edge select code
	function automatic logic edgeHit(input logic [1:0] sel, input logic prev, input logic cur);
		case (sel)
			timer_pkg::EDGE_RISING:  edgeHit = !prev && cur;
			timer_pkg::EDGE_FALLING: edgeHit = prev && !cur;
			timer_pkg::EDGE_BOTH:    edgeHit = prev != cur;
			default:                 edgeHit = 1'b0;
		endcase
	endfunction : edgeHit

	// Output effect code applied to a level
	function automatic logic applyEffect(input logic cur, input logic [1:0] code);
		case (code)
			timer_pkg::EFFECT_SET:    applyEffect = 1'b1;
			timer_pkg::EFFECT_CLEAR:  applyEffect = 1'b0;
			timer_pkg::EFFECT_TOGGLE: applyEffect = !cur;
			default:                  applyEffect = cur;
		endcase
	endfunction : applyEffect

	// Mode fields; the wave bit decides which layout applies
	logic       waveMode;
	logic       captureMode;
	logic [2:0] countClockSource;
	logic       countEdgeInvert;
	logic [1:0] gateSelect;
	assign waveMode         = modeReg[timer_pkg::MODE_WAVE];
	assign captureMode      = !waveMode;
	assign countClockSource = modeReg[timer_pkg::MODE_CLOCK_SOURCE +: 3];
	assign countEdgeInvert  = modeReg[timer_pkg::MODE_EDGE_INVERT];
	assign gateSelect       = modeReg[timer_pkg::MODE_GATE_SELECT +: 2];
	logic [1:0] patternSelect;
	logic       patternUpDown;
	logic       patternAuto;
	logic [1:0] eventSourceSelect;
	assign patternSelect     = modeReg[timer_pkg::WAV_PATTERN +: 2];
	assign patternUpDown     = waveMode && patternSelect[0];
	assign patternAuto       = patternSelect[1];
	assign eventSourceSelect = modeReg[timer_pkg::WAV_EVENT_SOURCE +: 2];

	// Bus decode; the window index sits above the stride offset bits
	logic addrValid;
	assign addrValid = hsel && hready && htrans[1] && (haddr[7:6] == timer_pkg::CHANNEL_INDEX);
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Address phase capture for writes
	always_ff @(posedge clk) begin
		if (reset) begin
			wrPending <= 1'b0;
			wrOffset  <= 6'h00;
		end else begin
			wrPending <= addrValid && hwrite;
			if (addrValid) begin
				wrOffset <= haddr[5:0];
			end
		end
	end

	// Command decode; only bits written as one act
	logic cmdWr;
	logic cmdOn;
	logic cmdOff;
	logic swTrig;
	assign cmdWr  = wrPending && (wrOffset == timer_pkg::OFS_COMMAND);
	assign cmdOn  = cmdWr && hwdata[timer_pkg::CMD_CLOCK_ON];
	assign cmdOff = cmdWr && hwdata[timer_pkg::CMD_CLOCK_OFF];
	assign swTrig = cmdWr && hwdata[timer_pkg::CMD_SOFT_TRIG];

	// Read data, registered at the address phase edge
	always_ff @(posedge clk) begin
		if (reset) begin
			hrdata <= 32'h00000000;
		end else if (addrValid && !hwrite) begin
			case (haddr[5:0])
				timer_pkg::OFS_MODE:  hrdata <= modeReg;
				timer_pkg::OFS_COUNT: hrdata <= {16'h0000, liveCount};
				timer_pkg::OFS_REG_A: hrdata <= {16'h0000, regA};
				timer_pkg::OFS_REG_B: hrdata <= {16'h0000, regB};
				timer_pkg::OFS_REG_C: hrdata <= {16'h0000, regC};
				// Write-only and unmapped read as zero
				default:              hrdata <= 32'h00000000;
			endcase
		end
	end

	// Free-running divider for internal clocks
	always_ff @(posedge clk) begin
		if (reset) begin
			prescale <= 16'h0000;
		end else begin
			prescale <= prescale + 16'h0001;
		end
	end

	logic selClk;
	always_comb begin
		case (countClockSource)
			3'h0:    selClk = prescale[timer_pkg::INT_CLOCK_TAP_1];
			3'h1:    selClk = prescale[timer_pkg::INT_CLOCK_TAP_2];
			3'h2:    selClk = prescale[timer_pkg::INT_CLOCK_TAP_3];
			3'h3:    selClk = prescale[timer_pkg::INT_CLOCK_TAP_4];
			3'h4:    selClk = prescale[timer_pkg::INT_CLOCK_TAP_5];
			3'h5:    selClk = extClockIn0;
			3'h6:    selClk = extClockIn1;
			default: selClk = extClockIn2;
		endcase
	end

	// Optional gating by an external input
	logic gateLevel;
	always_comb begin
		case (gateSelect)
			2'h1:    gateLevel = extClockIn0;
			2'h2:    gateLevel = extClockIn1;
			2'h3:    gateLevel = extClockIn2;
			default: gateLevel = 1'b1;
		endcase
	end

	// Counting edge of the gated clock
	logic clkLevel;
	logic edgeTick;
	logic tick;
	assign clkLevel = selClk && gateLevel;
	assign edgeTick = countEdgeInvert ? (prevClkLevel && !clkLevel) : (!prevClkLevel && clkLevel);
	assign tick     = edgeTick && clkEnabled && !clkStopped;

	// Previous levels for edge detection
	always_ff @(posedge clk) begin
		if (reset) begin
			prevClkLevel <= 1'b0;
			prevLineA    <= 1'b0;
			prevLineB    <= 1'b0;
			prevExt      <= 3'h0;
		end else begin
			prevClkLevel <= clkLevel;
			prevLineA    <= ioLineAIn;
			prevLineB    <= ioLineBIn;
			prevExt      <= {extClockIn2, extClockIn1, extClockIn0};
		end
	end

	// Capture loads; A and B on line A edges
	logic loadA;
	logic loadB;
	assign loadA = captureMode && edgeHit(modeReg[timer_pkg::CAP_A_LOAD_EDGE +: 2], prevLineA, ioLineAIn);
	assign loadB = captureMode && edgeHit(modeReg[timer_pkg::CAP_B_LOAD_EDGE +: 2], prevLineA, ioLineAIn);

	// Capture trigger line and its edge
	logic capLine;
	logic capPrev;
	logic capTrig;
	assign capLine = modeReg[timer_pkg::CAP_TRIGGER_LINE] ? ioLineAIn : ioLineBIn;
	assign capPrev = modeReg[timer_pkg::CAP_TRIGGER_LINE] ? prevLineA : prevLineB;
	assign capTrig = captureMode && edgeHit(modeReg[timer_pkg::CAP_TRIGGER_EDGE +: 2], capPrev, capLine);

	// Waveform event source and its edge
	logic evLine;
	logic evPrev;
	logic extEvent;
	always_comb begin
		case (eventSourceSelect)
			2'h1:    evLine = extClockIn0;
			2'h2:    evLine = extClockIn1;
			2'h3:    evLine = extClockIn2;
			default: evLine = ioLineBIn;
		endcase
		case (eventSourceSelect)
			2'h1:    evPrev = prevExt[0];
			2'h2:    evPrev = prevExt[1];
			2'h3:    evPrev = prevExt[2];
			default: evPrev = prevLineB;
		endcase
	end
	assign extEvent = waveMode && edgeHit(modeReg[timer_pkg::WAV_EVENT_EDGE +: 2], evPrev, evLine);

	// Compare matches at a counting edge
	logic matchA;
	logic matchB;
	logic matchC;
	assign matchA = tick && (liveCount == regA);
	assign matchB = tick && (liveCount == regB);
	assign matchC = tick && (liveCount == regC);

	// Trigger sources
	logic trigger;
	always_comb begin
		trigger = swTrig || capTrig;
		// External event restarts only when enabled
		if (extEvent && modeReg[timer_pkg::WAV_EVENT_RESTART]) begin
			trigger = 1'b1;
		end
		if (captureMode && modeReg[timer_pkg::CAP_MATCH_RESTART] && matchC) begin
			trigger = 1'b1;
		end
		if (waveMode && patternAuto && !patternSelect[0] && matchC) begin
			trigger = 1'b1;
		end
	end

	// Clock disable and stop events
	logic disableEvt;
	logic stopEvt;
	assign disableEvt = cmdOff
		|| (captureMode && modeReg[timer_pkg::CAP_DISABLE_ON_B] && loadB)
		|| (waveMode && modeReg[timer_pkg::WAV_DISABLE_ON_C] && matchC);
	assign stopEvt = (captureMode && modeReg[timer_pkg::CAP_HALT_ON_B] && loadB)
		|| (waveMode && modeReg[timer_pkg::WAV_HALT_ON_C] && matchC);

	// Clock enable state
	always_ff @(posedge clk) begin
		if (reset) begin
			clkEnabled <= 1'b0;
		end else if (disableEvt) begin
			clkEnabled <= 1'b0;
		end else if (cmdOn) begin
			clkEnabled <= 1'b1;
		end
	end

	// Clock stop state
	always_ff @(posedge clk) begin
		if (reset) begin
			clkStopped <= 1'b0;
		// Stop on load B or match C
		end else if (stopEvt) begin
			clkStopped <= 1'b1;
		end else if (trigger) begin
			clkStopped <= 1'b0;
		end
	end

	// Counter and direction
	logic [15:0] turnTop;
	assign turnTop = patternAuto ? regC : timer_pkg::COUNT_TOP;
	always_ff @(posedge clk) begin
		if (reset) begin
			liveCount <= timer_pkg::COUNT_RESET;
			countDown <= 1'b0;
		end else if (trigger) begin
			if (patternUpDown) begin
				countDown <= !countDown;
			end else begin
				liveCount <= timer_pkg::COUNT_RESET;
				countDown <= 1'b0;
			end
		end else if (tick) begin
			if (patternUpDown) begin
				// Turn at the top and at zero
				if (!countDown && (liveCount == turnTop)) begin
					countDown <= 1'b1;
					liveCount <= liveCount - 16'h0001;
				end else if (countDown && (liveCount == 16'h0000)) begin
					countDown <= 1'b0;
					liveCount <= liveCount + 16'h0001;
				end else if (countDown) begin
					liveCount <= liveCount - 16'h0001;
				end else begin
					liveCount <= liveCount + 16'h0001;
				end
			end else begin
				// Up-only, wraps past the top
				liveCount <= liveCount + 16'h0001;
			end
		end
	end

	// Compare and capture registers
	always_ff @(posedge clk) begin
		if (reset) begin
			modeReg <= timer_pkg::MODE_RESET;
			regA    <= timer_pkg::COUNT_RESET;
			regB    <= timer_pkg::COUNT_RESET;
			regC    <= timer_pkg::COUNT_RESET;
		end else begin
			if (wrPending && (wrOffset == timer_pkg::OFS_MODE)) begin
				modeReg <= hwdata;
			end
			if (wrPending && (wrOffset == timer_pkg::OFS_REG_C)) begin
				regC <= hwdata[15:0];
			end
			// A and B written only in waveform
			if (loadA) begin
				regA <= liveCount;
			end else if (waveMode && wrPending && (wrOffset == timer_pkg::OFS_REG_A)) begin
				regA <= hwdata[15:0];
			end
			if (loadB) begin
				regB <= liveCount;
			end else if (waveMode && wrPending && (wrOffset == timer_pkg::OFS_REG_B)) begin
				regB <= hwdata[15:0];
			end
		end
	end

	// Output effects; soft trigger applied last so it wins
	always_comb begin
		next_lineA = ioLineAOut;
		next_lineB = ioLineBOut;
		if (matchA) begin
			next_lineA = applyEffect(next_lineA, modeReg[timer_pkg::WAV_A_MATCH_A +: 2]);
		end
		if (matchB) begin
			next_lineB = applyEffect(next_lineB, modeReg[timer_pkg::WAV_B_MATCH_B +: 2]);
		end
		if (matchC) begin
			next_lineA = applyEffect(next_lineA, modeReg[timer_pkg::WAV_A_MATCH_C +: 2]);
			next_lineB = applyEffect(next_lineB, modeReg[timer_pkg::WAV_B_MATCH_C +: 2]);
		end
		if (extEvent) begin
			next_lineA = applyEffect(next_lineA, modeReg[timer_pkg::WAV_A_EVENT +: 2]);
			next_lineB = applyEffect(next_lineB, modeReg[timer_pkg::WAV_B_EVENT +: 2]);
		end
		if (swTrig) begin
			next_lineA = applyEffect(next_lineA, modeReg[timer_pkg::WAV_A_SOFT +: 2]);
			next_lineB = applyEffect(next_lineB, modeReg[timer_pkg::WAV_B_SOFT +: 2]);
		end
	end

	// Output line registers, held in capture mode
	always_ff @(posedge clk) begin
		if (reset) begin
			ioLineAOut <= 1'b0;
			ioLineBOut <= 1'b0;
		end else if (waveMode) begin
			ioLineAOut <= next_lineA;
			// Line B as input makes no waveform
			if (eventSourceSelect != 2'h0) begin
				ioLineBOut <= next_lineB;
			end
		end
	end

	// Drive enables
	assign ioLineAOe = waveMode;
	assign ioLineBOe = waveMode && (eventSourceSelect != 2'h0);

	a_soft_trig_zero: assert property (@(posedge clk) disable iff (reset)
		swTrig && !patternUpDown |=> liveCount == 16'h0000) else $error("soft trigger did not zero count");
	a_clock_off_wins: assert property (@(posedge clk) disable iff (reset)
		cmdOff |=> !clkEnabled) else $error("clock off command ignored");
	a_clock_on_cmd: assert property (@(posedge clk) disable iff (reset)
		cmdOn && !disableEvt |=> clkEnabled) else $error("clock on command ignored");
	a_zero_cmd_inert: assert property (@(posedge clk) disable iff (reset)
		cmdWr && (hwdata[2:0] == 3'h0) && !disableEvt |=> $stable(clkEnabled)) else $error("zero command acted");
	a_b_load_value: assert property (@(posedge clk) disable iff (reset)
		loadB |=> regB == $past(liveCount)) else $error("register B capture wrong");
	a_b_load_halt: assert property (@(posedge clk) disable iff (reset)
		loadB && modeReg[timer_pkg::CAP_HALT_ON_B] |=> clkStopped ##1 (!tick || $past(trigger)))
		else $error("B load did not stop clock");
	a_up_step: assert property (@(posedge clk) disable iff (reset)
		tick && !trigger && !patternUpDown |=> liveCount == $past(liveCount) + 16'h0001) else $error("count step wrong");
	a_top_turn: assert property (@(posedge clk) disable iff (reset)
		tick && !trigger && patternUpDown && !countDown && liveCount == turnTop
		|=> countDown && liveCount == $past(turnTop) - 16'h0001) else $error("up/down turn wrong");
	a_count_read: assert property (@(posedge clk) disable iff (reset)
		addrValid && !hwrite && haddr[5:0] == timer_pkg::OFS_COUNT
		|=> hrdata == {16'h0000, $past(liveCount)}) else $error("count read wrong");
	a_a_read_only: assert property (@(posedge clk) disable iff (reset)
		captureMode && !loadA |=> $stable(regA)) else $error("register A changed in capture");
	a_line_b_input: assert property (@(posedge clk) disable iff (reset)
		eventSourceSelect == 2'h0 |-> !ioLineBOe ##1 $stable(ioLineBOut)) else $error("line B driven as input");
	a_match_c_off: assert property (@(posedge clk) disable iff (reset)
		matchC && waveMode && modeReg[timer_pkg::WAV_DISABLE_ON_C] |=> !clkEnabled ##1 (!clkEnabled || $past(cmdOn)))
		else $error("match C disable failed");
endmodule : timer_channel_control_mode

// ### logic/timer_pkg.sv
// Constants shared by the timer channel: register map, field positions, codes, reset values
package timer_pkg;
	// Register offsets within one channel's window
	localparam logic [5:0] OFS_COMMAND = 6'h00;
	localparam logic [5:0] OFS_MODE    = 6'h04;
	localparam logic [5:0] OFS_COUNT   = 6'h10;
	localparam logic [5:0] OFS_REG_A   = 6'h14;
	localparam logic [5:0] OFS_REG_B   = 6'h18;
	localparam logic [5:0] OFS_REG_C   = 6'h1C;
	// Channel windows repeat at this stride; this instance answers for one index
	localparam logic [7:0] CHANNEL_STRIDE = 8'h40;
	localparam logic [1:0] CHANNEL_INDEX  = 2'h0;
	// Command bit positions
	localparam int CMD_CLOCK_ON  = 0;
	localparam int CMD_CLOCK_OFF = 1;
	localparam int CMD_SOFT_TRIG = 2;
	// Mode fields shared by both layouts
	localparam int MODE_CLOCK_SOURCE = 0;
	localparam int MODE_EDGE_INVERT  = 3;
	localparam int MODE_GATE_SELECT  = 4;
	localparam int MODE_WAVE         = 15;
	// Capture layout
	localparam int CAP_HALT_ON_B     = 6;
	localparam int CAP_DISABLE_ON_B  = 7;
	localparam int CAP_TRIGGER_EDGE  = 8;
	localparam int CAP_TRIGGER_LINE  = 10;
	localparam int CAP_MATCH_RESTART = 14;
	localparam int CAP_A_LOAD_EDGE   = 16;
	localparam int CAP_B_LOAD_EDGE   = 18;
	// Waveform layout
	localparam int WAV_HALT_ON_C     = 6;
	localparam int WAV_DISABLE_ON_C  = 7;
	localparam int WAV_EVENT_EDGE    = 8;
	localparam int WAV_EVENT_SOURCE  = 10;
	localparam int WAV_EVENT_RESTART = 12;
	localparam int WAV_PATTERN       = 13;
	localparam int WAV_A_MATCH_A     = 16;
	localparam int WAV_A_MATCH_C     = 18;
	localparam int WAV_A_EVENT       = 20;
	localparam int WAV_A_SOFT        = 22;
	localparam int WAV_B_MATCH_B     = 24;
	localparam int WAV_B_MATCH_C     = 26;
	localparam int WAV_B_EVENT       = 28;
	localparam int WAV_B_SOFT        = 30;
	// Output effect codes
	localparam logic [1:0] EFFECT_NONE   = 2'h0;
	localparam logic [1:0] EFFECT_SET    = 2'h1;
	localparam logic [1:0] EFFECT_CLEAR  = 2'h2;
	localparam logic [1:0] EFFECT_TOGGLE = 2'h3;
	// Edge select codes
	localparam logic [1:0] EDGE_NONE    = 2'h0;
	localparam logic [1:0] EDGE_RISING  = 2'h1;
	localparam logic [1:0] EDGE_FALLING = 2'h2;
	localparam logic [1:0] EDGE_BOTH    = 2'h3;
	// Prescaler tap for each internal clock (divide by 2, 8, 32, 128, 512)
	localparam logic [3:0] INT_CLOCK_TAP_1 = 4'h0;
	localparam logic [3:0] INT_CLOCK_TAP_2 = 4'h2;
	localparam logic [3:0] INT_CLOCK_TAP_3 = 4'h4;
	localparam logic [3:0] INT_CLOCK_TAP_4 = 4'h6;
	localparam logic [3:0] INT_CLOCK_TAP_5 = 4'h8;
	// Reset values and limits
	localparam logic [31:0] MODE_RESET  = 32'h00000000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_TOP   = 16'hFFFF;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
endpackage : timer_pkg

// ### dv/timer_line_partner.sv
// External clock inputs and line levels facing one timer channel
`timescale 1ns/10ps
module timer_line_partner (
	// Clock
	input  wire logic clk,
	// Lines from the channel
	input  wire logic ioLineAOut,
	input  wire logic ioLineAOe,
	input  wire logic ioLineBOut,
	input  wire logic ioLineBOe,
	// Levels toward the channel
	output logic      extClockIn0,
	output logic      extClockIn1,
	output logic      extClockIn2,
	output logic      ioLineAIn,
	output logic      ioLineBIn
);
	logic [2:0] ext  = 3'h0; // External clock levels
	logic       drvA = 1'b0; // Our level on line A
	logic       drvB = 1'b0; // Our level on line B
	// Wire level: the channel wins while it drives
	assign ioLineAIn = ioLineAOe ? ioLineAOut : drvA;
	assign ioLineBIn = ioLineBOe ? ioLineBOut : drvB;
	assign {extClockIn2, extClockIn1, extClockIn0} = ext;
	// Full pulses on one clock input, two cycles high, three cycles low between pulses and two after the last
	task pulse(input int idx, input int n);
		repeat (n) begin
			@(posedge clk);
			ext[idx] <= 1'b1;
			repeat (2) @(posedge clk);
			ext[idx] <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask : pulse
	// Our level on line A, changed just after a clock edge
	task setLineA(input logic v);
		@(posedge clk);
		drvA <= v;
	endtask : setLineA
endmodule : timer_line_partner

// ### dv/timer_channel_control_mode_bench.sv
// Self-checking bench for the timer channel
`timescale 1ns/10ps
module timer_channel_control_mode_bench;
	localparam logic [7:0] A_CMD = 8'(timer_pkg::OFS_COMMAND); // Byte addresses
	localparam logic [7:0] A_MOD = 8'(timer_pkg::OFS_MODE);
	localparam logic [7:0] A_CNT = 8'(timer_pkg::OFS_COUNT);
	localparam logic [7:0] A_RA  = 8'(timer_pkg::OFS_REG_A);
	localparam logic [7:0] A_RB  = 8'(timer_pkg::OFS_REG_B);
	localparam logic [7:0] A_RC  = 8'(timer_pkg::OFS_REG_C);
	logic        clk        = 1'b0;  // Bus clock
	logic        reset      = 1'b1;  // Synchronous reset
	logic        hsel       = 1'b0;  // Master select
	logic [31:0] haddr      = 32'h0; // Master address
	logic [1:0]  htrans     = 2'h0;  // Master transfer kind
	logic        hwrite     = 1'b0;  // Master direction
	logic [31:0] hwdata     = 32'h0; // Master write data
	wire         hreadyout;          // Slave ready, fed back
	wire         hresp;              // Slave response
	wire  [31:0] hrdata;             // Slave read data
	wire         ext0, ext1, ext2;   // External clocks
	wire         lineAIn, lineBIn;   // Wire levels
	wire         lineAOut, lineAOe;  // Line A drive
	wire         lineBOut, lineBOe;  // Line B drive
	logic        rdPhase    = 1'b0;  // Read data phase
	logic        lineStrobe = 1'b0;  // Line levels due
	logic [31:0] expQ[$];            // Expected results
	logic [31:0] seed       = 32'h19; // Random state
	logic [31:0] r;                  // Random mode value
	logic        a;                  // Expected line A
	int          errors     = 0;
	int          compares   = 0;
	int          n;
	// Clock at 40 MHz
	initial forever #12.5 clk = ~clk;
	// Design under test
	timer_channel_control_mode u_timer_channel_control_mode (.clk(clk), .reset(reset), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .extClockIn0(ext0), .extClockIn1(ext1),
		.extClockIn2(ext2), .ioLineAIn(lineAIn), .ioLineAOut(lineAOut), .ioLineAOe(lineAOe),
		.ioLineBIn(lineBIn), .ioLineBOut(lineBOut), .ioLineBOe(lineBOe));
	// Far side model
	timer_line_partner u_timer_line_partner (.clk(clk), .ioLineAOut(lineAOut), .ioLineAOe(lineAOe),
		.ioLineBOut(lineBOut), .ioLineBOe(lineBOe), .extClockIn0(ext0), .extClockIn1(ext1),
		.extClockIn2(ext2), .ioLineAIn(lineAIn), .ioLineBIn(lineBIn));
	// Xorshift generator
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// One single transfer: address phase, then data phase
	task xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
		haddr <= {24'h0, adr};
		hwrite <= wr;
		htrans <= timer_pkg::HTRANS_NONSEQ;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		rdPhase <= !wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rdPhase <= 1'b0;
	endtask : xfer
	// Read with its expected word noted
	task rd(input logic [7:0] adr, input logic [31:0] exp);
		expQ.push_back(exp);
		xfer(1'b0, adr, 32'h0);
	endtask : rd
	// Line levels {B enable, B out, A enable, A out} noted then sampled
	task probe(input logic [3:0] exp);
		expQ.push_back({28'h0, exp});
		@(posedge clk);
		lineStrobe <= 1'b1;
		@(posedge clk);
		lineStrobe <= 1'b0;
	endtask : probe
	// Compare one result with the oldest note
	task check(input logic [31:0] got);
		logic [31:0] exp;
		exp = expQ.pop_front();
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// Watcher of read data and line levels
	always @(posedge clk) begin
		if (rdPhase) begin
			// Response must always be OKAY
			compares++;
			if (hresp !== 1'b0) begin
				errors++;
				$display("wrong value at %0t: got %h expected %h", $time, hresp, 1'b0);
			end
			check(hrdata);
		end
		if (lineStrobe) check({28'h0, lineBOe, lineBOut, lineAOe, lineAOut});
	end
	// Counts, verdict and end of run
	task end_of_test();
		$display("comparisons %0d mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_of_test
	// Cut a hang short
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		end_of_test();
	end
	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		hsel <= 1'b1;
		rd(A_MOD, timer_pkg::MODE_RESET);
		rd(A_CNT, 32'h0);
		rd(A_CMD, 32'h0);
		rd({2'h1, timer_pkg::OFS_MODE}, 32'h0);
		r = rnd();
		xfer(1'b1, A_MOD, r);
		rd(A_MOD, r);
		$display("test registers done");
		n = 32'(rnd() % 4 + 1);
		xfer(1'b1, A_MOD, 32'h5);
		xfer(1'b1, A_CMD, 32'h5);
		u_timer_line_partner.pulse(0, n);
		rd(A_CNT, 32'(n));
		xfer(1'b1, A_CMD, 32'h3);
		u_timer_line_partner.pulse(0, 2);
		rd(A_CNT, 32'(n));
		xfer(1'b1, A_CMD, 32'h0);
		u_timer_line_partner.pulse(0, 1);
		rd(A_CNT, 32'(n));
		xfer(1'b1, A_CMD, 32'h1);
		u_timer_line_partner.pulse(0, 2);
		rd(A_CNT, 32'(n + 2));
		xfer(1'b1, A_CMD, 32'h4);
		rd(A_CNT, 32'h0);
		xfer(1'b1, A_MOD, 32'h16);
		u_timer_line_partner.pulse(1, 2);
		rd(A_CNT, 32'h0);
		xfer(1'b1, A_MOD, 32'h6);
		u_timer_line_partner.pulse(1, 2);
		rd(A_CNT, 32'h2);
		xfer(1'b1, A_RA, 32'h1234);
		rd(A_RA, 32'h0);
		$display("test counting done");
		xfer(1'b1, A_MOD, 32'hC005);
		xfer(1'b1, A_RC, 32'h2);
		xfer(1'b1, A_CMD, 32'h5);
		u_timer_line_partner.pulse(0, 5);
		rd(A_CNT, 32'h2);
		xfer(1'b1, A_RA, 32'h1234);
		rd(A_RA, 32'h1234);
		a = 1'b0;
		for (int k = 0; k < 4; k++) begin
			r = {30'h0, k == 0 ? timer_pkg::EFFECT_CLEAR : k == 1 ? timer_pkg::EFFECT_SET :
				k == 2 ? timer_pkg::EFFECT_TOGGLE : timer_pkg::EFFECT_NONE};
			a = r == 32'h1 ? 1'b1 : r == 32'h2 ? 1'b0 : r == 32'h3 ? ~a : a;
			xfer(1'b1, A_MOD, 32'h8000 | (r << timer_pkg::WAV_A_SOFT));
			xfer(1'b1, A_CMD, 32'h4);
			probe({3'b001, a});
		end
		xfer(1'b1, A_MOD, 32'h8400 | (32'h1 << timer_pkg::WAV_B_SOFT));
		xfer(1'b1, A_CMD, 32'h4);
		probe({3'b111, a});
		$display("test lines done");
		xfer(1'b1, A_MOD, 32'h40045);
		xfer(1'b1, A_CMD, 32'h5);
		u_timer_line_partner.pulse(0, 3);
		u_timer_line_partner.setLineA(1'b1);
		u_timer_line_partner.pulse(0, 2);
		rd(A_RB, 32'h3);
		rd(A_CNT, 32'h3);
		xfer(1'b1, A_CMD, 32'h4);
		u_timer_line_partner.pulse(0, 1);
		rd(A_CNT, 32'h1);
		xfer(1'b1, A_MOD, 32'hE005);
		u_timer_line_partner.pulse(0, 4);
		rd(A_CNT, 32'h1);
		xfer(1'b1, A_CMD, 32'h4);
		u_timer_line_partner.pulse(0, 1);
		rd(A_CNT, 32'h0);
		$display("test capture and up/down done");
		end_of_test();
	end
endmodule : timer_channel_control_mode_bench
